// >>> hdl/core_register_file_stacks.sv
/*
   Core register file: data registers, banked stack pointers, program
   counter, status word views, priority mask and thread control.
   Assumes the execution and exception logic share i_sys_clk, and that a
   vector source answers the reset vector request.
*/
// Summary of operation
// - Push decrements pointer, then stores item
// - Separate main and process stack pointers
// - Handler mode always uses main pointer
// - Thread mode: select bit picks pointer
// - Index 13 stack, 14 link, 15 counter
// - Thirteen data registers, link unknown at reset
// - Four stack pointers across two states
// - Program counter loaded from reset vector
// - Execution bit 24 from vector bit 0
// - Views occupy disjoint fields of one word
// - Flags N Z C V at bits 31-28
// - Status views alone or combined
// - Exception number writes are ignored
// - Execution bits read zero, ignore writes
// - Mask, exception number, control reset zero
// - Mask and control banked per state
// - Exception field holds current exception number
// - Mask bit blocks configurable exceptions
`timescale 1ns/10ps
module core_register_file_stacks
   import core_regs_pkg::*;
(
   // Clock, reset, enable
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst,
   input  wire logic              i_clk_en,
   // Reset vector fetch
   input  wire logic              i_vec_valid,
   input  wire logic [WORD_W-1:0] i_vec_data,
   output logic                   o_vec_req,
   output logic      [WORD_W-1:0] o_vec_addr,
   output logic                   o_ready,
   // Core register read
   input  wire logic              i_rd_en,
   input  wire logic [IDX_W-1:0]  i_rd_idx,
   output logic      [WORD_W-1:0] o_rd_data,
   // Core register write
   input  wire logic              i_wr_en,
   input  wire logic [IDX_W-1:0]  i_wr_idx,
   input  wire logic [WORD_W-1:0] i_wr_data,
   // Special register moves
   input  wire logic              i_sr_rd_en,
   input  wire logic              i_sr_wr_en,
   input  wire sr_sel_t           i_sr_sel,
   input  wire logic [WORD_W-1:0] i_sr_wr_data,
   output logic      [WORD_W-1:0] o_sr_rd_data,
   // Execution state updates
   input  wire logic              i_secure,
   input  wire logic              i_flags_we,
   input  wire logic [3:0]        i_flags,
   input  wire logic              i_exc_we,
   input  wire logic [EXC_W-1:0]  i_exc_num,
   input  wire logic              i_tbit_we,
   input  wire logic              i_tbit,
   // Stack operations
   input  wire logic              i_push,
   input  wire logic              i_pop,
   input  wire logic [WORD_W-1:0] i_push_data,
   output logic                   o_stack_wr_en,
   output logic      [WORD_W-1:0] o_stack_addr,
   output logic      [WORD_W-1:0] o_stack_wr_data,
   // Status out
   output logic                   o_handler,
   output logic                   o_sp_sel,
   output logic                   o_tbit,
   output logic      [3:0]        o_flags,
   output logic                   o_prio_block
);

   typedef enum logic {PH_VECTOR, PH_RUN} phase_t;

   typedef struct packed {
      phase_t                  phase;
      logic [WORD_W-1:0]       prog_cnt;
      logic [WORD_W-1:0]       main_sp_s;
      logic [WORD_W-1:0]       proc_sp_s;
      logic [WORD_W-1:0]       main_sp_ns;
      logic [WORD_W-1:0]       proc_sp_ns;
      logic [3:0]              flags;
      logic [EXC_W-1:0]        exc_num;
      logic                    tbit;
      logic                    pm_s;
      logic                    pm_ns;
      logic [CTRL_W-1:0]       ctrl_s;
      logic [CTRL_W-1:0]       ctrl_ns;
      logic [WORD_W-1:0]       rd_data;
      logic [WORD_W-1:0]       sr_rd_data;
      logic [WORD_W-1:0]       stack_addr;
      logic [WORD_W-1:0]       stack_wr_data;
      logic [WORD_W-1:0]       vec_addr;
      logic                    stack_wr_en;
      logic                    vec_req;
      logic                    handler;
      logic                    sp_sel;
      logic                    prio_block;
   } state_t;

   state_t q;
   state_t next_q;

   logic              run;
   logic              use_proc;
   logic [WORD_W-1:0] active_sp;
   logic [WORD_W-1:0] sp_val;
   logic              sp_we;
   logic              gp_we;
   logic [WORD_W-1:0] gp_rd_data;
   logic [WORD_W-1:0] view_word;
   logic              view_flags_ok;
   logic [3:0]        view_wr_flags;

   function automatic logic [IDX_W-1:0] gp_slot(input logic [IDX_W-1:0] idx);
      gp_slot = (idx == IDX_LINK) ? LINK_SLOT : idx;
   endfunction : gp_slot

   function automatic logic [WORD_W-1:0] align_sp(input logic [WORD_W-1:0] val);
      align_sp = val & SP_ALIGN_MASK;
   endfunction : align_sp

   assign run = (q.phase == PH_RUN);

   assign use_proc  = (q.exc_num == EXC_THREAD) && (i_secure ? q.ctrl_s[STACK_SELECT_BIT_POS] : q.ctrl_ns[STACK_SELECT_BIT_POS]);
   assign active_sp = i_secure ? (use_proc ? q.proc_sp_s : q.main_sp_s)
                               : (use_proc ? q.proc_sp_ns : q.main_sp_ns);

   assign gp_we = run && i_wr_en && (i_wr_idx != IDX_STACK_PTR) && (i_wr_idx != IDX_PROG_CNT);

   gp_reg_array #(
      .WIDTH (WORD_W),
      .DEPTH (GP_DEPTH)
   ) i_gp_reg_array (
      .i_sys_clk (i_sys_clk),
      .i_clk_en  (i_clk_en),
      .i_wr_en   (gp_we),
      .i_wr_slot (gp_slot(i_wr_idx)),
      .i_wr_data (i_wr_data),
      .i_rd_slot (gp_slot(i_rd_idx)),
      .o_rd_data (gp_rd_data)
   );

   status_view_port i_status_view_port (
      .i_sel         (i_sr_sel),
      .i_flags       (q.flags),
      .i_exc_num     (q.exc_num),
      .i_wr_data     (i_sr_wr_data),
      .o_rd_word     (view_word),
      .o_flags_wr_ok (view_flags_ok),
      .o_wr_flags    (view_wr_flags)
   );

   always_comb
   begin
      next_q             = q;
      next_q.stack_wr_en = 1'b0;
      sp_we              = 1'b0;
      sp_val             = active_sp;

      if (q.phase == PH_VECTOR && i_vec_valid)
      begin
         next_q.prog_cnt = {i_vec_data[WORD_W-1:1], 1'b0};
         next_q.tbit     = i_vec_data[0];
         next_q.vec_req  = 1'b0;
         next_q.phase    = PH_RUN;
      end

      if (run)
      begin
         if (i_rd_en)
         begin
            unique case (i_rd_idx)
               IDX_STACK_PTR: next_q.rd_data = active_sp;
               IDX_PROG_CNT:  next_q.rd_data = q.prog_cnt;
               default:       next_q.rd_data = gp_rd_data;
            endcase
         end
         if (i_wr_en && i_wr_idx == IDX_PROG_CNT)
         begin
            next_q.prog_cnt = i_wr_data;
         end
         if (i_wr_en && i_wr_idx == IDX_STACK_PTR)
         begin
            sp_we  = 1'b1;
            sp_val = align_sp(i_wr_data);
         end

         if (i_sr_rd_en)
         begin
            next_q.sr_rd_data = '0;
            unique case (i_sr_sel)
               SR_MAIN_SP:       next_q.sr_rd_data = i_secure ? q.main_sp_s : q.main_sp_ns;
               SR_PROC_SP:       next_q.sr_rd_data = i_secure ? q.proc_sp_s : q.proc_sp_ns;
               SR_PRIO_MASK:     next_q.sr_rd_data[PM_POS] = i_secure ? q.pm_s : q.pm_ns;
               SR_THREAD_CFG:    next_q.sr_rd_data[CTRL_W-1:0] = i_secure ? q.ctrl_s : q.ctrl_ns;
               SR_MAIN_SP_NS:    next_q.sr_rd_data = i_secure ? q.main_sp_ns : RST_WORD;
               SR_PROC_SP_NS:    next_q.sr_rd_data = i_secure ? q.proc_sp_ns : RST_WORD;
               SR_PRIO_MASK_NS:  next_q.sr_rd_data[PM_POS] = i_secure & q.pm_ns;
               SR_THREAD_CFG_NS: next_q.sr_rd_data[CTRL_W-1:0] = i_secure ? q.ctrl_ns : RST_CONTROL;
               default:          next_q.sr_rd_data = view_word;
            endcase
         end

         if (i_sr_wr_en)
         begin
            if (view_flags_ok)
            begin
               next_q.flags = view_wr_flags;
            end
            unique case (i_sr_sel)
               SR_MAIN_SP:
               begin
                  if (i_secure) next_q.main_sp_s = align_sp(i_sr_wr_data);
                  else next_q.main_sp_ns = align_sp(i_sr_wr_data);
               end
               SR_PROC_SP:
               begin
                  if (i_secure) next_q.proc_sp_s = align_sp(i_sr_wr_data);
                  else next_q.proc_sp_ns = align_sp(i_sr_wr_data);
               end
               SR_PRIO_MASK:
               begin
                  if (i_secure) next_q.pm_s = i_sr_wr_data[PM_POS];
                  else next_q.pm_ns = i_sr_wr_data[PM_POS];
               end
               SR_THREAD_CFG:
               begin
                  if (i_secure) next_q.ctrl_s = i_sr_wr_data[CTRL_W-1:0];
                  else next_q.ctrl_ns = i_sr_wr_data[CTRL_W-1:0];
               end
               SR_MAIN_SP_NS:    if (i_secure) next_q.main_sp_ns = align_sp(i_sr_wr_data);
               SR_PROC_SP_NS:    if (i_secure) next_q.proc_sp_ns = align_sp(i_sr_wr_data);
               SR_PRIO_MASK_NS:  if (i_secure) next_q.pm_ns = i_sr_wr_data[PM_POS];
               SR_THREAD_CFG_NS: if (i_secure) next_q.ctrl_ns = i_sr_wr_data[CTRL_W-1:0];
               default:          ;
            endcase
         end

         if (i_flags_we)
         begin
            next_q.flags = i_flags;
         end
         if (i_exc_we)
         begin
            next_q.exc_num = i_exc_num;
         end
         if (i_tbit_we)
         begin
            next_q.tbit = i_tbit;
         end

         if (i_push)
         begin
            sp_we                = 1'b1;
            sp_val               = active_sp - SP_STEP;
            next_q.stack_addr    = active_sp - SP_STEP;
            next_q.stack_wr_data = i_push_data;
            next_q.stack_wr_en   = 1'b1;
         end
         else if (i_pop)
         begin
            sp_we             = 1'b1;
            sp_val            = active_sp + SP_STEP;
            next_q.stack_addr = active_sp;
         end
      end

      if (sp_we)
      begin
         unique case ({i_secure, use_proc})
            2'b11: next_q.proc_sp_s  = sp_val;
            2'b10: next_q.main_sp_s  = sp_val;
            2'b01: next_q.proc_sp_ns = sp_val;
            2'b00: next_q.main_sp_ns = sp_val;
         endcase
      end

      next_q.handler    = (next_q.exc_num != EXC_THREAD);
      next_q.sp_sel     = !next_q.handler && (i_secure ? next_q.ctrl_s[STACK_SELECT_BIT_POS] : next_q.ctrl_ns[STACK_SELECT_BIT_POS]);
      next_q.prio_block = next_q.pm_s | next_q.pm_ns;
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         q          <= '0;
         q.phase    <= PH_VECTOR;
         q.exc_num  <= RST_EXC;
         q.ctrl_s   <= RST_CONTROL;
         q.ctrl_ns  <= RST_CONTROL;
         q.pm_s     <= RST_PRIORITY_MASK;
         q.pm_ns    <= RST_PRIORITY_MASK;
         q.vec_addr <= VEC_ADDR;
         q.vec_req  <= 1'b1;
      end
      else if (i_clk_en)
      begin
         q <= next_q;
      end
   end

   assign o_vec_req       = q.vec_req;
   assign o_vec_addr      = q.vec_addr;
   assign o_ready         = run;
   assign o_rd_data       = q.rd_data;
   assign o_sr_rd_data    = q.sr_rd_data;
   assign o_stack_wr_en   = q.stack_wr_en;
   assign o_stack_addr    = q.stack_addr;
   assign o_stack_wr_data = q.stack_wr_data;
   assign o_handler       = q.handler;
   assign o_sp_sel        = q.sp_sel;
   assign o_tbit          = q.tbit;
   assign o_flags         = q.flags;
   assign o_prio_block    = q.prio_block;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   AST_PUSH_DESCEND: assert property (
      (run && i_clk_en && i_push) |=> (o_stack_wr_en && o_stack_addr == $past(active_sp) - SP_STEP))
      else $error("Push did not predecrement the stack pointer");

   AST_BANK_ISOLATE: assert property (
      (run && i_clk_en && i_push && i_secure && !i_sr_wr_en) |=> ($stable(q.main_sp_ns) && $stable(q.proc_sp_ns)))
      else $error("Secure push disturbed a non-secure pointer");

   AST_HANDLER_MAIN: assert property (
      o_handler |-> (!o_sp_sel && active_sp == (i_secure ? q.main_sp_s : q.main_sp_ns)))
      else $error("Handler mode selected the process pointer");

   AST_ALIAS_SP: assert property (
      (run && i_clk_en && i_rd_en && i_rd_idx == IDX_STACK_PTR) |=> (o_rd_data == $past(active_sp)))
      else $error("Index 13 did not return the active pointer");

   AST_VECTOR_LOAD: assert property (
      (q.phase == PH_VECTOR && i_clk_en && i_vec_valid)
      |=> (o_ready && !o_vec_req && q.prog_cnt == {$past(i_vec_data[WORD_W-1:1]), 1'b0}))
      else $error("Program counter not loaded from reset vector");

   AST_TBIT_LOAD: assert property (
      (q.phase == PH_VECTOR && i_clk_en && i_vec_valid) |=> (o_tbit == $past(i_vec_data[0])))
      else $error("Execution bit not taken from vector bit 0");

   AST_EXC_WRITE_IGNORED: assert property (
      (run && i_clk_en && i_sr_wr_en && view_is_status(i_sr_sel) && !i_exc_we) |=> $stable(q.exc_num))
      else $error("Status view write changed the exception number");

   AST_EXEC_READ_ZERO: assert property (
      (run && i_clk_en && i_sr_rd_en && view_is_status(i_sr_sel)) |=> (o_sr_rd_data[TBIT_POS] == 1'b0))
      else $error("Execution bit visible through a status view");

   AST_RESERVED_ZERO: assert property (
      (run && i_clk_en && i_sr_rd_en && view_is_status(i_sr_sel)) |=> (o_sr_rd_data[FLAGS_LSB-1:EXC_W] == '0))
      else $error("Reserved status bits not zero");

   AST_RESET_CLEAR: assert property (
      $past(i_rst) |-> (q.exc_num == RST_EXC && q.ctrl_s == RST_CONTROL && !q.pm_s && !o_prio_block))
      else $error("Mask, exception number or control not cleared at reset");

   AST_MASK_BLOCK: assert property (
      (i_clk_en && run && i_sr_wr_en && i_sr_sel == SR_PRIO_MASK && i_sr_wr_data[PM_POS]) |=> o_prio_block)
      else $error("Mask bit set without blocking");

   COV_PUSH:   cover property (run && i_push ##1 o_stack_wr_en);
   COV_PROC:   cover property (o_sp_sel ##1 o_handler);
   COV_VIEW:   cover property (run && i_sr_rd_en && i_sr_sel == SR_ALL);
   COV_VECTOR: cover property (o_vec_req ##1 o_ready);

endmodule : core_register_file_stacks

// >>> include/core_regs_pkg.sv
/*
   Constants, selector codes and view decode helpers for the core register file.
   Assumes one 32-bit core clock domain and a 6-bit exception number field.
*/
package core_regs_pkg;

   localparam int WORD_W    = 32;
   localparam int IDX_W     = 4;
   localparam int EXC_W     = 6;
   localparam int GP_DEPTH  = 14;
   localparam int FLAGS_LSB = 28;
   localparam int TBIT_POS  = 24;
   localparam int STACK_SELECT_BIT_POS = 1;
   localparam int PM_POS    = 0;
   localparam int CTRL_W    = 2;

   localparam logic [3:0]  IDX_STACK_PTR = 4'hD;
   localparam logic [3:0]  IDX_LINK      = 4'hE;
   localparam logic [3:0]  IDX_PROG_CNT  = 4'hF;
   localparam logic [3:0]  LINK_SLOT     = 4'hD;

   localparam logic [31:0] VEC_ADDR      = 32'h0000_0004;
   localparam logic [31:0] SP_STEP       = 32'h0000_0004;
   localparam logic [31:0] SP_ALIGN_MASK = 32'hFFFF_FFFC;
   localparam logic [31:0] RST_WORD      = 32'h0000_0000;
   localparam logic [5:0]  RST_EXC       = 6'h00;
   localparam logic [1:0]  RST_CONTROL   = 2'h0;
   localparam logic        RST_PRIORITY_MASK   = 1'h0;

   // Exception numbers seen in the exception field
   localparam logic [5:0]  EXC_THREAD     = 6'h00;
   localparam logic [5:0]  EXC_NMI        = 6'h02;
   localparam logic [5:0]  EXC_HARD_FAULT = 6'h03;
   localparam logic [5:0]  EXC_SUPV_CALL  = 6'h0B;
   localparam logic [5:0]  EXC_PEND_SERV  = 6'h0E;
   localparam logic [5:0]  EXC_TICK       = 6'h0F;
   localparam logic [5:0]  EXC_IRQ_BASE   = 6'h10;

   typedef enum logic [3:0] {
      SR_FLAGS, SR_EXC, SR_EXEC, SR_ALL, SR_EXC_EXEC, SR_FLAGS_EXC, SR_FLAGS_EXEC,
      SR_MAIN_SP, SR_PROC_SP, SR_PRIO_MASK, SR_THREAD_CFG,
      SR_MAIN_SP_NS, SR_PROC_SP_NS, SR_PRIO_MASK_NS, SR_THREAD_CFG_NS
   } sr_sel_t;

   function automatic logic view_has_flags(input sr_sel_t sel);
      view_has_flags = (sel == SR_FLAGS) || (sel == SR_ALL) || (sel == SR_FLAGS_EXC) || (sel == SR_FLAGS_EXEC);
   endfunction : view_has_flags

   function automatic logic view_has_exc(input sr_sel_t sel);
      view_has_exc = (sel == SR_EXC) || (sel == SR_ALL) || (sel == SR_EXC_EXEC) || (sel == SR_FLAGS_EXC);
   endfunction : view_has_exc

   function automatic logic view_is_status(input sr_sel_t sel);
      view_is_status = (sel <= SR_FLAGS_EXEC);
   endfunction : view_is_status

endpackage : core_regs_pkg

// >>> hdl/gp_reg_array.sv
/*
   Storage for the thirteen data registers and the link register.
   Assumes the caller maps indices to slots; contents are not reset.
*/
`timescale 1ns/10ps
module gp_reg_array
   import core_regs_pkg::*;
#(
   parameter int WIDTH = WORD_W,
   parameter int DEPTH = GP_DEPTH
)
(
   // Clock
   input  wire logic              i_sys_clk,
   input  wire logic              i_clk_en,
   // Write side
   input  wire logic              i_wr_en,
   input  wire logic [IDX_W-1:0]  i_wr_slot,
   input  wire logic [WIDTH-1:0]  i_wr_data,
   // Read side
   input  wire logic [IDX_W-1:0]  i_rd_slot,
   output logic      [WIDTH-1:0]  o_rd_data
);

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge i_sys_clk)
   begin
      if (i_clk_en && i_wr_en && (int'(i_wr_slot) < DEPTH))
      begin
         mem[i_wr_slot] <= i_wr_data;
      end
   end

   assign o_rd_data = (int'(i_rd_slot) < DEPTH) ? mem[i_rd_slot] : '0;

endmodule : gp_reg_array

// >>> hdl/status_view_port.sv
/*
   Builds the read word of a status view and the flag write of a view.
   Assumes the selector is decoded with the package helpers.
*/
`timescale 1ns/10ps
module status_view_port
   import core_regs_pkg::*;
(
   // View selection
   input  wire sr_sel_t           i_sel,
   // Current status fields
   input  wire logic [3:0]        i_flags,
   input  wire logic [EXC_W-1:0]  i_exc_num,
   // Write data
   input  wire logic [WORD_W-1:0] i_wr_data,
   // Results
   output logic      [WORD_W-1:0] o_rd_word,
   output logic                   o_flags_wr_ok,
   output logic      [3:0]        o_wr_flags
);

   always_comb
   begin
      o_rd_word = '0;
      if (view_has_flags(i_sel))
      begin
         o_rd_word[FLAGS_LSB +: 4] = i_flags;
      end
      if (view_has_exc(i_sel))
      begin
         o_rd_word[EXC_W-1:0] = i_exc_num;
      end
   end

   assign o_flags_wr_ok = view_has_flags(i_sel);
   assign o_wr_flags    = i_wr_data[FLAGS_LSB +: 4];

endmodule : status_view_port

// >>> test/vec_source_model.sv
/*
   Reset vector source standing in for the execution side.
   Assumes the register file holds its vector request until answered.
*/
`timescale 1ns/10ps
module vec_source_model
#(
   parameter logic [31:0] VEC_WORD = 32'h0000_1235,
   parameter int          LAG      = 3
)
(
   // Clock
   input  wire logic        i_sys_clk,
   // Request
   input  wire logic        i_vec_req,
   // Answer
   output logic             o_vec_valid,
   output logic [31:0]      o_vec_data
);
   int wait_cnt = 0;
   initial
   begin
      o_vec_valid = 1'b0;
      o_vec_data  = ~VEC_WORD;
   end
   always @(negedge i_sys_clk)
   begin
      wait_cnt    <= i_vec_req ? wait_cnt + 1 : 0;
      o_vec_valid <= i_vec_req && (wait_cnt >= LAG);
      o_vec_data  <= (i_vec_req && (wait_cnt >= LAG)) ? VEC_WORD : ~o_vec_data;
   end
endmodule : vec_source_model

// >>> test/tb_core_register_file_stacks.sv
/*
   Self-checking bench for the core register file.
   Assumes the vector source model answers the reset vector request.
*/
`timescale 1ns/10ps
module tb_core_register_file_stacks
   import core_regs_pkg::*;
;
   localparam logic [31:0] VEC   = 32'h0000_1235;
   localparam logic [6:0]  FMASK = 7'b110_1001;
   localparam logic [6:0]  EMASK = 7'b011_1010;
   logic        i_sys_clk, i_rst, i_clk_en, i_vec_valid, o_vec_req, o_ready, i_rd_en, i_wr_en;
   logic        i_sr_rd_en, i_sr_wr_en, i_secure, i_flags_we, i_exc_we, i_tbit_we, i_tbit, i_push, i_pop;
   logic        o_stack_wr_en, o_handler, o_sp_sel, o_tbit, o_prio_block;
   logic [3:0]  i_rd_idx, i_wr_idx, i_flags, o_flags;
   logic [5:0]  i_exc_num;
   logic [31:0] i_vec_data, o_vec_addr, o_rd_data, i_wr_data, i_sr_wr_data, o_sr_rd_data;
   logic [31:0] i_push_data, o_stack_addr, o_stack_wr_data, val;
   sr_sel_t     i_sr_sel;
   int          errors = 0, cmp_count = 0, cycles = 0;

   core_register_file_stacks i_core_register_file_stacks (
      .i_sys_clk, .i_rst, .i_clk_en, .i_vec_valid, .i_vec_data, .o_vec_req, .o_vec_addr, .o_ready,
      .i_rd_en, .i_rd_idx, .o_rd_data, .i_wr_en, .i_wr_idx, .i_wr_data,
      .i_sr_rd_en, .i_sr_wr_en, .i_sr_sel, .i_sr_wr_data, .o_sr_rd_data,
      .i_secure, .i_flags_we, .i_flags, .i_exc_we, .i_exc_num, .i_tbit_we, .i_tbit,
      .i_push, .i_pop, .i_push_data, .o_stack_wr_en, .o_stack_addr, .o_stack_wr_data,
      .o_handler, .o_sp_sel, .o_tbit, .o_flags, .o_prio_block);

   vec_source_model #(.VEC_WORD(VEC), .LAG(3)) i_vec_source_model (
      .i_sys_clk(i_sys_clk), .i_vec_req(o_vec_req), .o_vec_valid(i_vec_valid), .o_vec_data(i_vec_data));

   initial
   begin
      i_sys_clk = 1'b0;
      forever #4 i_sys_clk = ~i_sys_clk;
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [3:0] idx, input logic [31:0] d);
      {i_wr_en, i_wr_idx, i_wr_data} = {1'b1, idx, d};
      @(negedge i_sys_clk);
      i_wr_en = 1'b0;
      @(negedge i_sys_clk);
   endtask : wr

   task automatic rd(input logic [3:0] idx);
      {i_rd_en, i_rd_idx} = {1'b1, idx};
      @(negedge i_sys_clk);
      i_rd_en = 1'b0;
      val = o_rd_data;
      @(negedge i_sys_clk);
   endtask : rd

   task automatic srw(input sr_sel_t sel, input logic [31:0] d);
      {i_sr_wr_en, i_sr_wr_data} = {1'b1, d};
      i_sr_sel = sel;
      @(negedge i_sys_clk);
      i_sr_wr_en = 1'b0;
      @(negedge i_sys_clk);
   endtask : srw

   task automatic srr(input sr_sel_t sel);
      i_sr_rd_en = 1'b1;
      i_sr_sel = sel;
      @(negedge i_sys_clk);
      i_sr_rd_en = 1'b0;
      val = o_sr_rd_data;
      @(negedge i_sys_clk);
   endtask : srr

   // Status updates from the execution side, then settle
   task automatic exc(input logic [5:0] n);
      {i_exc_we, i_exc_num} = {1'b1, n};
      @(negedge i_sys_clk);
      {i_exc_we, i_flags_we, i_tbit_we} = 3'b000;
      @(negedge i_sys_clk);
   endtask : exc

   task automatic t_reset();
      chk("vec_addr", o_vec_addr, 32'h0000_0004);
      chk("ready", 32'(o_ready), 32'h0);
      chk("vec_req", 32'(o_vec_req), 32'h1);
      i_rst = 1'b0;
      repeat (50) if (o_ready !== 1'b1) @(negedge i_sys_clk);
      @(negedge i_sys_clk);
      chk("vec_done", 32'(o_vec_req), 32'h0);
      chk("tbit", 32'(o_tbit), 32'h1);
      rd(4'hF);
      chk("pc", val, VEC & 32'hFFFF_FFFE);
      srr(SR_PRIO_MASK);
      chk("mask", val, 32'h0);
      srr(SR_THREAD_CFG);
      chk("cfg", val, 32'h0);
      srr(SR_EXC);
      chk("exc", val, 32'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_gpr();
      wr(4'h0, 32'hDEAD_0000);
      wr(4'hC, 32'h0000_BEEF);
      wr(4'hE, 32'h1111_2222);
      i_clk_en = 1'b0;
      wr(4'h0, 32'h0BAD_0BAD);
      i_clk_en = 1'b1;
      rd(4'h0);
      chk("r0", val, 32'hDEAD_0000);
      rd(4'hC);
      chk("r12", val, 32'h0000_BEEF);
      rd(4'hE);
      chk("link", val, 32'h1111_2222);
      $display("test gpr done");
   endtask : t_gpr

   task automatic t_stack();
      wr(4'hD, 32'h0000_0100);
      {i_push, i_push_data} = {1'b1, 32'hA5A5_0001};
      @(negedge i_sys_clk);
      i_push_data = 32'hA5A5_0002;
      chk("push1", {o_stack_addr[30:0], o_stack_wr_en}, {31'h0000_00FC, 1'b1});
      chk("data1", o_stack_wr_data, 32'hA5A5_0001);
      @(negedge i_sys_clk);
      i_push = 1'b0;
      chk("push2", {o_stack_addr[30:0], o_stack_wr_en}, {31'h0000_00F8, 1'b1});
      chk("data2", o_stack_wr_data, 32'hA5A5_0002);
      @(negedge i_sys_clk);
      chk("pulse", 32'(o_stack_wr_en), 32'h0);
      i_pop = 1'b1;
      @(negedge i_sys_clk);
      i_pop = 1'b0;
      chk("pop", {o_stack_addr[30:0], o_stack_wr_en}, {31'h0000_00F8, 1'b0});
      rd(4'hD);
      chk("sp", val, 32'h0000_00FC);
      $display("test stack done");
   endtask : t_stack

   task automatic t_bank();
      srw(SR_THREAD_CFG, 32'h0000_0002);
      chk("sp_sel", 32'(o_sp_sel), 32'h1);
      rd(4'hD);
      chk("psp", val, 32'h0);
      wr(4'hD, 32'h0000_0203);
      srr(SR_PROC_SP);
      chk("psp_w", val, 32'h0000_0200);
      srr(SR_MAIN_SP);
      chk("msp", val, 32'h0000_00FC);
      exc(6'h03);
      chk("handler", {30'h0, o_handler, o_sp_sel}, 32'h2);
      rd(4'hD);
      chk("hsp", val, 32'h0000_00FC);
      exc(6'h00);
      i_secure = 1'b0;
      rd(4'hD);
      chk("ns_sp", val, 32'h0);
      srw(SR_PRIO_MASK, 32'h0000_0001);
      chk("block", 32'(o_prio_block), 32'h1);
      i_secure = 1'b1;
      srr(SR_PRIO_MASK);
      chk("s_mask", val, 32'h0);
      srw(SR_PRIO_MASK_NS, 32'h0000_0000);
      chk("unblock", 32'(o_prio_block), 32'h0);
      $display("test bank done");
   endtask : t_bank

   task automatic t_psr();
      {i_flags_we, i_flags, i_tbit_we, i_tbit} = {1'b1, 4'hA, 2'b11};
      exc(6'h0B);
      for (int k = 0; k < 7; k++)
      begin
         srr(sr_sel_t'(k));
         chk("view", val, {FMASK[k] ? 4'hA : 4'h0, 22'h0, EMASK[k] ? 6'h0B : 6'h00});
      end
      srw(SR_ALL, 32'hFEFF_FFFF);
      chk("all_wr", {o_flags, o_tbit}, 5'h1F);
      srr(SR_EXC);
      chk("exc_kept", val, 32'h0000_000B);
      srw(SR_FLAGS_EXEC, 32'h5000_0000);
      srw(SR_EXC_EXEC, 32'hFFFF_FFFF);
      chk("flags", 32'(o_flags), 32'h5);
      exc(6'h00);
      $display("test psr done");
   endtask : t_psr

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report

   always @(posedge i_sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         final_report();
      end
   end

   initial
   begin
      {i_rst, i_clk_en, i_secure} = 3'b111;
      {i_rd_en, i_wr_en, i_sr_rd_en, i_sr_wr_en, i_flags_we, i_exc_we, i_tbit_we, i_tbit, i_push, i_pop} = '0;
      {i_rd_idx, i_wr_idx, i_flags, i_exc_num, i_wr_data, i_sr_wr_data, i_push_data} = '0;
      i_sr_sel = SR_FLAGS;
      repeat (5) @(negedge i_sys_clk);
      t_reset();
      t_gpr();
      t_stack();
      t_bank();
      t_psr();
      final_report();
   end
endmodule : tb_core_register_file_stacks
